// ---- hw/pin_change_edge_detect.sv ----
// Top of the pin change edge detector with register port and interrupt
//
// Overview of operation
// - Rising enable bit set makes a low-to-high pin edge set its flag.
// - Falling enable bit set makes a high-to-low pin edge set its flag.
// - A flag reads one once an enabled edge was seen on its pin.
// - Flag reads zero after software wrote zero to it, until the next enabled edge or a write of one.
// - Flags are set by hardware and read and written by software.
// - Port B enable and flag bits three to zero read as zero.
// - All enable and flag bits reset to zero on every reset.
// - Edges still set flags while the master enable is clear.
// - Summary flag is the OR of all port A and port B flags.
// - An edge during a flag-clearing write leaves that flag set.
// - With master enable set an enabled edge requests wake-up, flags already updated.
//
// The placing of the registers and the strobed register port were left to the implementer.
`include "pin_change_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module pin_change_edge_detect (
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_resetn,
    input  wire logic [5:0]             i_porta_pin_n,
    input  wire logic [3:0]             i_portb_pin_n,
    input  wire logic [`PC_ADDR_W-1:0]  i_addr,
    input  wire logic [`PC_DATA_W-1:0]  i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [`PC_DATA_W-1:0]  o_rdata,
    output logic                        o_change_irq,
    output logic                        o_wake,
    output logic                        o_irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // Decode
    function automatic logic hit_addr(input logic [`PC_ADDR_W-1:0] a, input logic [`PC_ADDR_W-1:0] off);
        hit_addr = (a == off);
    endfunction

    pin_change_pkg::byte_t a_rise, a_fall, a_flags, b_rise, b_fall, b_flags;
    logic                  a_hit, b_hit;
    logic                  master_en_q;
    logic [`PC_STAT_W-1:0] stat_q;
    logic [`PC_STAT_W-1:0] mask_q;
    logic                  summary;
    pin_edge_if            edges ();

    pin_sync_edge u_sync (
        .i_clk_sys     (i_clk_sys),
        .i_resetn      (i_resetn),
        .i_porta_pin_n (i_porta_pin_n),
        .i_portb_pin_n (i_portb_pin_n),
        .edges         (edges.detector)
    );

    change_flag_reg #(.IMPL(`PC_PORTA_MASK)) u_porta (
        .i_clk_sys   (i_clk_sys),
        .i_resetn    (i_resetn),
        .i_wr_rise   (i_wr && hit_addr(i_addr, `PC_OFF_PORTA_RISE)),
        .i_wr_fall   (i_wr && hit_addr(i_addr, `PC_OFF_PORTA_FALL)),
        .i_wr_flags  (i_wr && hit_addr(i_addr, `PC_OFF_PORTA_FLAGS)),
        .i_wdata     (i_wdata),
        .i_rise_edge (edges.porta_rise),
        .i_fall_edge (edges.porta_fall),
        .o_rise_en   (a_rise),
        .o_fall_en   (a_fall),
        .o_flags     (a_flags),
        .o_hit       (a_hit)
    );

    change_flag_reg #(.IMPL(`PC_PORTB_MASK)) u_portb (
        .i_clk_sys   (i_clk_sys),
        .i_resetn    (i_resetn),
        .i_wr_rise   (i_wr && hit_addr(i_addr, `PC_OFF_PORTB_RISE)),
        .i_wr_fall   (i_wr && hit_addr(i_addr, `PC_OFF_PORTB_FALL)),
        .i_wr_flags  (i_wr && hit_addr(i_addr, `PC_OFF_PORTB_FLAGS)),
        .i_wdata     (i_wdata),
        .i_rise_edge (edges.portb_rise),
        .i_fall_edge (edges.portb_fall),
        .o_rise_en   (b_rise),
        .o_fall_en   (b_fall),
        .o_flags     (b_flags),
        .o_hit       (b_hit)
    );

    assign summary = (|a_flags) | (|b_flags);

    ////////////////////////////////////////////////////////////////////////////////
    // Core control: master enable
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            master_en_q <= 1'b0;
        end else if (i_wr && hit_addr(i_addr, `PC_OFF_CORE_IRQ_CTRL)) begin
            master_en_q <= i_wdata[`PC_CTRL_MASTER_EN];
        end
    end

    // Master enable gates only the request, never detection
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_change_irq <= 1'b0;
            o_wake       <= 1'b0;
        end else begin
            o_change_irq <= master_en_q & summary;
            o_wake       <= master_en_q & (a_hit | b_hit);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear; a new event wins over the clear
    logic [`PC_STAT_W-1:0] stat_ev;
    assign stat_ev = {master_en_q & (a_hit | b_hit), b_hit, a_hit};

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            stat_q <= '0;
        end else if (i_wr && hit_addr(i_addr, `PC_OFF_IRQ_STATUS)) begin
            stat_q <= (stat_q & ~i_wdata[`PC_STAT_W-1:0]) | stat_ev;
        end else begin
            stat_q <= stat_q | stat_ev;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            mask_q <= '0;
        end else if (i_wr && hit_addr(i_addr, `PC_OFF_IRQ_MASK)) begin
            mask_q <= i_wdata[`PC_STAT_W-1:0];
        end
    end

    // Registered, so the line lags the status by one cycle
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(stat_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port; unmapped addresses read zero
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            unique case (i_addr)
                `PC_OFF_PORTA_RISE:    o_rdata <= a_rise;
                `PC_OFF_PORTA_FALL:    o_rdata <= a_fall;
                `PC_OFF_PORTA_FLAGS:   o_rdata <= a_flags;
                `PC_OFF_PORTB_RISE:    o_rdata <= b_rise;
                `PC_OFF_PORTB_FALL:    o_rdata <= b_fall;
                `PC_OFF_PORTB_FLAGS:   o_rdata <= b_flags;
                `PC_OFF_CORE_IRQ_CTRL: o_rdata <= {4'h0, master_en_q, 2'b00, summary};
                `PC_OFF_IRQ_STATUS:    o_rdata <= {5'h00, stat_q};
                `PC_OFF_IRQ_MASK:      o_rdata <= {5'h00, mask_q};
                default:               o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_flag_set;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (|(edges.porta_rise & a_rise)) |=> (|a_flags);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Enabled rising edge did not set flag");

    property p_fall_set;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (|(edges.portb_fall & b_fall)) |=> (|b_flags);
    endproperty
    a_fall_set: assert property (p_fall_set) else $error("Enabled falling edge did not set flag");

    property p_stay;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (a_flags[0] && !(i_wr && hit_addr(i_addr, `PC_OFF_PORTA_FLAGS))) |=> a_flags[0];
    endproperty
    a_stay: assert property (p_stay) else $error("Flag dropped without a write");

    property p_clear;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && hit_addr(i_addr, `PC_OFF_PORTA_FLAGS) && !i_wdata[0] && !a_hit) |=> !a_flags[0];
    endproperty
    a_clear: assert property (p_clear) else $error("Zero write did not clear flag");

    property p_b_low;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (b_flags[3:0] == 4'h0) && (b_rise[3:0] == 4'h0) && (b_fall[3:0] == 4'h0);
    endproperty
    a_b_low: assert property (p_b_low) else $error("Unimplemented port B bits set");

    property p_race;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && hit_addr(i_addr, `PC_OFF_PORTB_FLAGS) && (|(edges.portb_rise & b_rise))) |=> (|b_flags);
    endproperty
    a_race: assert property (p_race) else $error("Edge lost during flag write");

    property p_detect_off;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (!master_en_q && summary) |=> !o_change_irq;
    endproperty
    a_detect_off: assert property (p_detect_off) else $error("Request raised while master enable clear");

    property p_summary;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_rd && hit_addr(i_addr, `PC_OFF_CORE_IRQ_CTRL)) |=> (o_rdata[`PC_CTRL_SUMMARY] == $past(summary));
    endproperty
    a_summary: assert property (p_summary) else $error("Summary flag read wrong");

    property p_wake;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (master_en_q && a_hit) |=> (o_wake && (|a_flags));
    endproperty
    a_wake: assert property (p_wake) else $error("Wake not raised with flag updated");

    // Per-bit record of what the previous clock had to set, so the checks below look at each pin
    pin_change_pkg::byte_t a_want_q;
    pin_change_pkg::byte_t b_want_q;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            a_want_q <= 8'h00;
            b_want_q <= 8'h00;
        end else begin
            a_want_q <= (edges.porta_rise & a_rise) | (edges.porta_fall & a_fall);
            b_want_q <= (edges.portb_rise & b_rise) | (edges.portb_fall & b_fall);
        end
    end

    property p_a_want;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        ((a_flags & a_want_q) == a_want_q);
    endproperty
    a_a_want: assert property (p_a_want) else $error("Port A enabled edge left its flag clear");

    property p_b_want;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        ((b_flags & b_want_q) == b_want_q);
    endproperty
    a_b_want: assert property (p_b_want) else $error("Port B enabled edge left its flag clear");

    property p_a_no_spurious;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !(i_wr && hit_addr(i_addr, `PC_OFF_PORTA_FLAGS)) |=> ((a_flags & ~$past(a_flags) & ~a_want_q) == 8'h00);
    endproperty
    a_a_no_spurious: assert property (p_a_no_spurious) else $error("Port A flag set with no enabled edge");

    property p_b_no_spurious;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !(i_wr && hit_addr(i_addr, `PC_OFF_PORTB_FLAGS)) |=> ((b_flags & ~$past(b_flags) & ~b_want_q) == 8'h00);
    endproperty
    a_b_no_spurious: assert property (p_b_no_spurious) else $error("Port B flag set with no enabled edge");

    property p_race_fall;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && hit_addr(i_addr, `PC_OFF_PORTB_FLAGS) && (|(edges.portb_fall & b_fall))) |=> (|b_flags);
    endproperty
    a_race_fall: assert property (p_race_fall) else $error("Falling edge lost during flag write");

    property p_a_flags_write;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && hit_addr(i_addr, `PC_OFF_PORTA_FLAGS) && !a_hit) |=> (a_flags == ($past(i_wdata) & `PC_PORTA_MASK));
    endproperty
    a_a_flags_write: assert property (p_a_flags_write) else $error("Port A flag write not stored");

    property p_b_flags_write;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && hit_addr(i_addr, `PC_OFF_PORTB_FLAGS) && !b_hit) |=> (b_flags == ($past(i_wdata) & `PC_PORTB_MASK));
    endproperty
    a_b_flags_write: assert property (p_b_flags_write) else $error("Port B flag write not stored");

    property p_irq_level;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (o_change_irq == ($past(master_en_q) && $past(summary)));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Change request does not follow enable and flags");

    property p_wake_only;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !master_en_q |=> !o_wake;
    endproperty
    a_wake_only: assert property (p_wake_only) else $error("Wake raised while master enable clear");

    property p_wake_b;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (master_en_q && b_hit) |=> (o_wake && (|b_flags));
    endproperty
    a_wake_b: assert property (p_wake_b) else $error("Port B edge did not wake with flag updated");

    property p_b_read_low;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_rd && (hit_addr(i_addr, `PC_OFF_PORTB_RISE) || hit_addr(i_addr, `PC_OFF_PORTB_FALL) ||
                  hit_addr(i_addr, `PC_OFF_PORTB_FLAGS))) |=> (o_rdata[3:0] == 4'h0);
    endproperty
    a_b_read_low: assert property (p_b_read_low) else $error("Port B low bits read nonzero");

    property p_a_pulse;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        ((edges.porta_rise & $past(edges.porta_rise)) == 8'h00);
    endproperty
    a_a_pulse: assert property (p_a_pulse) else $error("Port A rise seen on two clocks in a row");

    property p_b_pulse;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        ((edges.portb_fall & $past(edges.portb_fall)) == 8'h00);
    endproperty
    a_b_pulse: assert property (p_b_pulse) else $error("Port B fall seen on two clocks in a row");

    property p_a_rise_write;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && hit_addr(i_addr, `PC_OFF_PORTA_RISE)) |=> (a_rise == ($past(i_wdata) & `PC_PORTA_MASK));
    endproperty
    a_a_rise_write: assert property (p_a_rise_write) else $error("Port A rise enable write not stored");

    property p_b_fall_write;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_wr && hit_addr(i_addr, `PC_OFF_PORTB_FALL)) |=> (b_fall == ($past(i_wdata) & `PC_PORTB_MASK));
    endproperty
    a_b_fall_write: assert property (p_b_fall_write) else $error("Port B fall enable write not stored");
endmodule
`default_nettype wire

// ---- hw/pin_change_defs.svh ----
// Register offsets, field positions, reset values and widths for the pin change block
`ifndef PIN_CHANGE_DEFS_SVH
`define PIN_CHANGE_DEFS_SVH

`define PC_ADDR_W            4
`define PC_DATA_W            8
`define PC_OFF_PORTA_RISE    4'h0
`define PC_OFF_PORTA_FALL    4'h1
`define PC_OFF_PORTA_FLAGS   4'h2
`define PC_OFF_PORTB_RISE    4'h3
`define PC_OFF_PORTB_FALL    4'h4
`define PC_OFF_PORTB_FLAGS   4'h5
`define PC_OFF_CORE_IRQ_CTRL 4'h6
`define PC_OFF_IRQ_STATUS    4'h7
`define PC_OFF_IRQ_MASK      4'h8
`define PC_PORTA_MASK        8'h3f
`define PC_PORTB_MASK        8'hf0
`define PC_RESET_VAL         8'h00
`define PC_CTRL_MASTER_EN    3
`define PC_CTRL_SUMMARY      0
`define PC_STAT_PORTA        0
`define PC_STAT_PORTB        1
`define PC_STAT_WAKE         2
`define PC_STAT_W            3

`endif

// ---- hw/pin_change_pkg.sv ----
// Types shared by the pin change block
package pin_change_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        PORT_A,
        PORT_B,
        PORT_NONE
    } port_sel_e;
endpackage

// ---- hw/pin_edge_if.sv ----
// Per-port rising and falling edge pulses passed between the detector and the register file
`timescale 1ns/10ps
`default_nettype none
interface pin_edge_if;
    logic [7:0] porta_rise;
    logic [7:0] porta_fall;
    logic [7:0] portb_rise;
    logic [7:0] portb_fall;
    modport detector (output porta_rise, output porta_fall, output portb_rise, output portb_fall);
    modport consumer (input porta_rise, input porta_fall, input portb_rise, input portb_fall);
endinterface
`default_nettype wire

// ---- hw/pin_sync_edge.sv ----
// Two-flop synchronisers and edge detectors for the port pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync_edge (
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire logic [5:0] i_porta_pin_n,
    input  wire logic [3:0] i_portb_pin_n,
    pin_edge_if.detector    edges
);
    logic [9:0] meta_q;
    logic [9:0] sync_q;
    logic [9:0] prev_q;
    logic [2:0] prime_q;

    // Meta stage feeds only the second stage
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= 10'h000;
            sync_q <= 10'h000;
        end else begin
            meta_q <= {i_portb_pin_n, i_porta_pin_n};
            sync_q <= meta_q;
        end
    end

    // Previous sample; edges held off until sync and previous sample both hold real pin data,
    // otherwise a pin that is high through reset would look like a rise
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            prev_q  <= 10'h000;
            prime_q <= 3'h0;
        end else begin
            prev_q  <= sync_q;
            prime_q <= {prime_q[1:0], 1'b1};
        end
    end

    logic [9:0] rise;
    logic [9:0] fall;
    assign rise = prime_q[2] ? (sync_q & ~prev_q) : 10'h000;
    assign fall = prime_q[2] ? (~sync_q & prev_q) : 10'h000;

    assign edges.porta_rise = {2'b00, rise[5:0]};
    assign edges.porta_fall = {2'b00, fall[5:0]};
    assign edges.portb_rise = {rise[9:6], 4'h0};
    assign edges.portb_fall = {fall[9:6], 4'h0};
endmodule
`default_nettype wire

// ---- hw/change_flag_reg.sv ----
// One port's edge enables and hardware-set change flags
`include "pin_change_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module change_flag_reg #(
    parameter logic [7:0] IMPL = 8'hff
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire logic       i_wr_rise,
    input  wire logic       i_wr_fall,
    input  wire logic       i_wr_flags,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] i_rise_edge,
    input  wire logic [7:0] i_fall_edge,
    output logic      [7:0] o_rise_en,
    output logic      [7:0] o_fall_en,
    output logic      [7:0] o_flags,
    output logic            o_hit
);
    logic [7:0] hit;
    assign hit   = IMPL & ((i_rise_edge & o_rise_en) | (i_fall_edge & o_fall_en));
    assign o_hit = |hit;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rise_en <= `PC_RESET_VAL;
            o_fall_en <= `PC_RESET_VAL;
        end else begin
            if (i_wr_rise) begin
                o_rise_en <= i_wdata & IMPL;
            end
            if (i_wr_fall) begin
                o_fall_en <= i_wdata & IMPL;
            end
        end
    end

    // An edge in the write cycle wins over the written value
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_flags <= `PC_RESET_VAL;
        end else if (i_wr_flags) begin
            o_flags <= (i_wdata & IMPL) | hit;
        end else begin
            o_flags <= o_flags | hit;
        end
    end
endmodule
`default_nettype wire

// ---- tb/pin_source.sv ----
// Model of the external digital pins that feed both ports
`timescale 1ns/10ps
`default_nettype none
module pin_source (
    input  wire logic       i_clk_sys,
    output logic      [5:0] o_porta,
    output logic      [3:0] o_portb
);
    initial begin
        o_porta = 6'h00;
        o_portb = 4'h0;
    end
    // Levels move just after an edge; no timing relation is promised, so the block must synchronise
    task automatic drive(input logic [5:0] a, input logic [3:0] b);
        @(posedge i_clk_sys);
        o_porta <= a;
        o_portb <= b;
    endtask
endmodule
`default_nettype wire

// ---- tb/pin_change_edge_detect_bench.sv ----
// Register-level testbench for the pin change edge detector
`include "pin_change_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module pin_change_edge_detect_bench;
    logic       i_clk_sys;
    logic       i_resetn;
    logic [3:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    logic [7:0] o_rdata;
    logic       o_change_irq;
    logic       o_wake;
    logic       o_irq;
    logic [5:0] porta;
    logic [3:0] portb;
    logic [7:0] v;
    int         mismatches;
    int         check_count;

    pin_source pin_source_i (.i_clk_sys(i_clk_sys), .o_porta(porta), .o_portb(portb));

    pin_change_edge_detect pin_change_edge_detect_i (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_porta_pin_n(porta), .i_portb_pin_n(portb),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_change_irq(o_change_irq), .o_wake(o_wake), .o_irq(o_irq)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check1(input string what, input logic exp, input logic got);
        check8(what, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk_sys);
        i_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk_sys);
        i_rd   <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        rd(a, v);
        check8(what, exp, v);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int seen;
        i_resetn = 1'b0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        mismatches = 0;
        check_count = 0;
        repeat (3) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        settle(3);
        for (int a = 0; a < 9; a++) rd_chk("reset value", 4'(a), 8'h00);
        rd_chk("unmapped", 4'hf, 8'h00);
        wr(`PC_OFF_PORTA_RISE, 8'hff);
        rd_chk("A rise width", `PC_OFF_PORTA_RISE, 8'h3f);
        wr(`PC_OFF_PORTB_RISE, 8'hff);
        rd_chk("B rise low bits", `PC_OFF_PORTB_RISE, 8'hf0);
        wr(`PC_OFF_PORTB_FALL, 8'hff);
        rd_chk("B fall low bits", `PC_OFF_PORTB_FALL, 8'hf0);
        wr(`PC_OFF_PORTB_FLAGS, 8'hff);
        rd_chk("B flags low bits", `PC_OFF_PORTB_FLAGS, 8'hf0);
        for (int a = 0; a < 6; a++) wr(4'(a), 8'h00);
        wr(`PC_OFF_IRQ_STATUS, 8'h07);
        wr(`PC_OFF_IRQ_MASK, 8'h01);
        rd_chk("irq mask", `PC_OFF_IRQ_MASK, 8'h01);
        // Pin 0 watches rising only, pin 1 falling only, master enable still clear
        wr(`PC_OFF_PORTA_RISE, 8'h01);
        wr(`PC_OFF_PORTA_FALL, 8'h02);
        pin_source_i.drive(6'h03, 4'h0);
        settle(6);
        rd_chk("A flags rise", `PC_OFF_PORTA_FLAGS, 8'h01);
        check1("change irq masked", 1'b0, o_change_irq);
        rd_chk("summary", `PC_OFF_CORE_IRQ_CTRL, 8'h01);
        pin_source_i.drive(6'h01, 4'h0);
        settle(6);
        rd_chk("A flags fall", `PC_OFF_PORTA_FLAGS, 8'h03);
        pin_source_i.drive(6'h00, 4'h0);
        settle(6);
        rd_chk("A flags disabled edge", `PC_OFF_PORTA_FLAGS, 8'h03);
        rd_chk("status A", `PC_OFF_IRQ_STATUS, 8'h01);
        check1("irq level", 1'b1, o_irq);
        wr(`PC_OFF_CORE_IRQ_CTRL, 8'h08);
        settle(2);
        check1("change irq on", 1'b1, o_change_irq);
        rd_chk("ctrl", `PC_OFF_CORE_IRQ_CTRL, 8'h09);
        wr(`PC_OFF_PORTA_FLAGS, 8'h00);
        settle(2);
        rd_chk("A flags cleared", `PC_OFF_PORTA_FLAGS, 8'h00);
        check1("change irq off", 1'b0, o_change_irq);
        wr(`PC_OFF_IRQ_STATUS, 8'h01);
        settle(2);
        check1("irq cleared", 1'b0, o_irq);
        // Port B pin 4 rising with master enable set must request wake-up
        wr(`PC_OFF_PORTB_RISE, 8'h10);
        pin_source_i.drive(6'h00, 4'h1);
        seen = 0;
        for (int i = 0; i < 12 && seen == 0; i++) begin
            @(posedge i_clk_sys);
            #1;
            if (o_wake === 1'b1) seen = 1;
        end
        check1("wake pulse", 1'b1, seen[0]);
        rd_chk("B flags rise", `PC_OFF_PORTB_FLAGS, 8'h10);
        rd_chk("status B wake", `PC_OFF_IRQ_STATUS, 8'h06);
        wr(`PC_OFF_PORTA_FLAGS, 8'h04);
        rd_chk("A flags sw set", `PC_OFF_PORTA_FLAGS, 8'h04);
        // Pin 4 falls while software clears port B flags; the clearing write lands on the detect cycle
        wr(`PC_OFF_PORTB_FLAGS, 8'h00);
        wr(`PC_OFF_PORTB_FALL, 8'h10);
        pin_source_i.drive(6'h00, 4'h0);
        @(posedge i_clk_sys);
        wr(`PC_OFF_PORTB_FLAGS, 8'h00);
        rd_chk("B flags race", `PC_OFF_PORTB_FLAGS, 8'h10);
        @(posedge i_clk_sys);
        i_resetn <= 1'b0;
        @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        settle(3);
        for (int a = 0; a < 9; a++) rd_chk("second reset", 4'(a), 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
